// ---- rtl/stc_timer.sv ----
`timescale 1ns/100ps
`include "stc_consts.svh"
// What this block does
// - wide mode maps high-byte address to a buffer register.
// - wide mode low-byte read snapshots live high byte into buffer.
// - wide mode low-byte write loads buffer into live high byte.
// - wide mode: live high byte only reachable through the buffer.
// - low-byte write clears prescaler; high-byte write does not.
// - source select 0 counts instruction cycles, 1 external edges.
// - sync disable chooses raw or synchronised external clock.
// - prescale field divides input by 1, 2, 4 or 8.
// - counter runs only while run enable is set.
// - timebase select 1x gives this counter, 00 the other timer.
// - oscillator enabled forces shared pins to inputs, reading zero.
// - sixteen-bit counter counts up and wraps to zero.
// - wrap sets sticky overflow flag; enable gates the interrupt.
// - compare trigger mode match resets counter, starts conversion.
// - software counter write beats a same-cycle trigger reset.
// - trigger reset never sets the overflow flag.
module stc_timer (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  // classic wishbone slave
  input  wire logic                 i_wb_cyc,
  input  wire logic                 i_wb_stb,
  input  wire logic                 i_wb_we,
  input  wire logic [7:0]           i_wb_adr,
  input  wire logic [31:0]          i_wb_dat,
  input  wire logic [3:0]           i_wb_sel,
  output logic [31:0]               o_wb_dat,
  output logic                      o_wb_ack,
  output logic                      o_wb_err,
  // external count input and oscillator
  input  wire logic                 i_ext_count,
  input  wire logic                 i_osc_clk,
  input  wire logic                 i_low_power_osc_enable,
  // compare unit trigger inputs
  input  wire logic [3:0]           i_compare_mode_code,
  input  wire logic                 i_compare_match,
  input  wire logic                 i_adc_enable,
  // shared port pins
  input  wire logic [1:0]           i_port_pins,
  input  wire logic [1:0]           i_port_direction_reg,
  output logic [1:0]                o_port_pins_oe_n,
  output logic [1:0]                o_port_pins_in,
  // time base routing and events
  output logic                      o_timebase_this,
  output logic                      o_adc_start,
  output logic [15:0]               o_count,
  output logic                      o_irq
);
  import stc_pkg::*;

  stc_bus_if bus ();

  // register state and internal strobes
  stc_pkg::stc_byte_t ctrl;
  logic [15:0]        count;
  stc_pkg::stc_byte_t high_buf;
  logic               ovf_status;
  logic               ovf_mask;
  logic [1:0]         iclk_div;
  logic               ext_src;
  logic               ext_s1;
  logic               ext_s2;
  logic               ext_prev;
  logic               ext_level;
  stc_edge_state_t    edge_state;
  logic               tick;
  logic               inc;
  logic               ext_rise;
  logic               wide;
  logic               trig;
  logic               wrap;
  logic               req;
  logic               ack;
  logic [31:0]        rdata;
  logic               mapped;
  logic               wr;
  logic               cnt_wr;

  // address match against a given register offset
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr == ofs);
  endfunction : hit

  // wide mode steers high-byte traffic through the buffer
  assign wide = ctrl[`STC_CTL_WIDE];

  // --------------------------------------------------------------
  // wishbone slave
  // --------------------------------------------------------------
  // one answer a cycle after the request; ack or err blocks a repeat
  assign req    = i_wb_cyc && i_wb_stb && !ack && !o_wb_err;
  assign mapped = hit(i_wb_adr, `STC_OFS_LOW) || hit(i_wb_adr, `STC_OFS_HIGH)
               || hit(i_wb_adr, `STC_OFS_CTRL)
               || hit(i_wb_adr, `STC_OFS_STATUS)
               || hit(i_wb_adr, `STC_OFS_MASK)
               || hit(i_wb_adr, `STC_OFS_PINS);
  assign wr     = req && mapped && i_wb_we && i_wb_sel[0];

  // strobes for the core; a low read in wide mode snapshots the high byte
  assign bus.low_rd  = req && !i_wb_we && hit(i_wb_adr, `STC_OFS_LOW);
  assign bus.low_wr  = wr && hit(i_wb_adr, `STC_OFS_LOW);
  assign bus.high_wr = wr && hit(i_wb_adr, `STC_OFS_HIGH);
  assign bus.wdata   = i_wb_dat[7:0];

  // read mux; high offset shows buffer in wide mode
  always_comb begin
    rdata = 32'h0000_0000;
    case (i_wb_adr)
      `STC_OFS_LOW:    rdata[7:0] = count[7:0];
      `STC_OFS_HIGH:   rdata[7:0] = wide ? high_buf : count[15:8];
      `STC_OFS_CTRL:   rdata[7:0] = ctrl;
      `STC_OFS_STATUS: rdata[0]   = ovf_status;
      `STC_OFS_MASK:   rdata[0]   = ovf_mask;
      `STC_OFS_PINS:   rdata[1:0] = o_port_pins_in;
      default:         rdata      = 32'h0000_0000;
    endcase
  end

  // ack pulse; the !ack term in req keeps it to one cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack <= 1'b0;
    end else begin
      ack <= req && mapped;
    end
  end
  assign o_wb_ack = ack;

  // error pulse for holes in the map, never together with ack
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_wb_err <= 1'b0;
    end else begin
      o_wb_err <= req && !mapped;
    end
  end

  // read data captured with the request, held until the next one
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_wb_dat <= 32'h0000_0000;
    end else if (req) begin
      o_wb_dat <= rdata;
    end
  end

  // --------------------------------------------------------------
  // control, mask and status registers
  // --------------------------------------------------------------
  // control register: plain read/write byte
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl <= `STC_CTRL_RST;
    end else if (wr && hit(i_wb_adr, `STC_OFS_CTRL)) begin
      ctrl <= i_wb_dat[7:0];
    end
  end

  // interrupt mask, same layout as status
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ovf_mask <= 1'b0;
    end else if (wr && hit(i_wb_adr, `STC_OFS_MASK)) begin
      ovf_mask <= i_wb_dat[`STC_ST_OVF];
    end
  end

  // set wins over write-one-to-clear so no wrap is lost
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ovf_status <= 1'b0;
    end else if (wrap) begin
      ovf_status <= 1'b1;
    end else if (wr && hit(i_wb_adr, `STC_OFS_STATUS)
                 && i_wb_dat[`STC_ST_OVF]) begin
      ovf_status <= 1'b0;
    end
  end
  assign o_irq = ovf_status && ovf_mask;

  // --------------------------------------------------------------
  // clock source selection
  // --------------------------------------------------------------
  // instruction cycle is one clock in four
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      iclk_div <= 2'h0;
    end else begin
      iclk_div <= iclk_div + 2'h1;
    end
  end

  // oscillator replaces the external input whenever its enable is set
  assign ext_src = i_low_power_osc_enable ? i_osc_clk : i_ext_count;

  // two-flop synchroniser; first stage read only by second
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
    end else begin
      ext_s1 <= ext_src;
      ext_s2 <= ext_s1;
    end
  end

  // previous level for edge detection; resets to the idle low level
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_level;
    end
  end

  // unsynchronised path still sampled once; single clock domain here
  assign ext_level = ctrl[`STC_CTL_SYNC_DIS] ? ext_src : ext_s2;
  assign ext_rise  = ext_level && !ext_prev && (edge_state == STC_EDGE_ARMED);

  // first rising edge only counts once a falling edge was seen
  always_ff @(posedge i_clk) begin
    if (i_rst || !ctrl[`STC_CTL_CLK_SEL]) begin
      edge_state <= STC_EDGE_WAIT_LOW;
    end else begin
      case (edge_state)
        STC_EDGE_WAIT_LOW: begin
          if (!ext_level && ext_prev) begin
            edge_state <= STC_EDGE_ARMED;
          end
        end
        STC_EDGE_ARMED: edge_state <= STC_EDGE_ARMED;
        default:        edge_state <= STC_EDGE_WAIT_LOW;
      endcase
    end
  end

  // run enable gates the source, so a stopped counter holds its prescaler
  assign tick = ctrl[`STC_CTL_RUN] && (ctrl[`STC_CTL_CLK_SEL] ? ext_rise
              : (iclk_div == `STC_ICLK_DIV));

  // prescaler restarts on every low-byte write
  stc_prescale u_prescale (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_tick  (tick),
    .i_clear (bus.low_wr),
    .i_sel   (ctrl[`STC_CTL_PS_HI:`STC_CTL_PS_LO]),
    .o_inc   (inc)
  );

  // --------------------------------------------------------------
  // counter and high byte buffer
  // --------------------------------------------------------------
  // trigger only in compare trigger mode on match, and only while this
  // counter is the enhanced unit's time base
  assign trig = i_compare_match && ctrl[`STC_CTL_ENH_SEL]
             && (i_compare_mode_code == `STC_SET_MODE);
  // a write reaching the live counter; a buffer-only write does not stall it
  assign cnt_wr = bus.low_wr || (bus.high_wr && !wide);
  // trigger clears without wrap flag
  assign wrap = inc && (count == `STC_CNT_MAX) && !trig
             && !cnt_wr;

  // live counter: software write first, then trigger, then count
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count <= `STC_CNT_RST;
    end else if (cnt_wr) begin
      // write wins over a same-cycle trigger
      if (bus.low_wr) begin
        count[7:0] <= bus.wdata;
        if (wide) begin
          count[15:8] <= high_buf;
        end
      end else begin
        count[15:8] <= bus.wdata;
      end
    end else if (trig) begin
      count <= `STC_CNT_RST;
    end else if (inc) begin
      count <= count + 16'h0001;
    end
  end

  // buffer: written directly, or snapshot of live high on low read
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      high_buf <= 8'h00;
    end else if (bus.high_wr && wide) begin
      high_buf <= bus.wdata;
    end else if (bus.low_rd && wide) begin
      high_buf <= count[15:8];
    end
  end

  // --------------------------------------------------------------
  // outputs to neighbours
  // --------------------------------------------------------------
  // conversion start pulse, one cycle after the trigger
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_adc_start <= 1'b0;
    end else begin
      o_adc_start <= trig && i_adc_enable;
    end
  end

  // time base routing follows the enhanced-unit select bit
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_timebase_this <= 1'b0;
    end else begin
      o_timebase_this <= ctrl[`STC_CTL_ENH_SEL];
    end
  end

  // registered copy of the count for neighbours; one cycle late
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_count <= `STC_CNT_RST;
    end else begin
      o_count <= count;
    end
  end

  // --------------------------------------------------------------
  // shared port pins
  // --------------------------------------------------------------
  // oscillator owns both pins: inputs that read zero
  for (genvar p = 0; p < $bits(o_port_pins_in); p++) begin : g_pin
    assign o_port_pins_oe_n[p] = i_low_power_osc_enable
                               || i_port_direction_reg[p];
    assign o_port_pins_in[p]   = !i_low_power_osc_enable
                               && i_port_pins[p];
  end
endmodule : stc_timer

// ---- rtl/stc_consts.svh ----
`ifndef STC_CONSTS_SVH
`define STC_CONSTS_SVH
// register offsets (byte addresses, one word each)
`define STC_OFS_LOW      8'h00
`define STC_OFS_HIGH     8'h04
`define STC_OFS_CTRL     8'h08
`define STC_OFS_STATUS   8'h0C
`define STC_OFS_MASK     8'h10
`define STC_OFS_PINS     8'h14
// control field positions
`define STC_CTL_WIDE     7
`define STC_CTL_ENH_SEL  6
`define STC_CTL_PS_HI    5
`define STC_CTL_PS_LO    4
`define STC_CTL_STD_SEL  3
`define STC_CTL_SYNC_DIS 2
`define STC_CTL_CLK_SEL  1
`define STC_CTL_RUN      0
// status / mask bit
`define STC_ST_OVF       0
// reset values and counter maximum
`define STC_CTRL_RST     8'h00
`define STC_CNT_RST      16'h0000
`define STC_CNT_MAX      16'hFFFF
// instruction clock divider
`define STC_ICLK_DIV     2'h3
// special event trigger mode code
`define STC_SET_MODE     4'hB
`endif

// ---- rtl/stc_pkg.sv ----
package stc_pkg;
  typedef enum logic [1:0] {
    STC_EDGE_WAIT_LOW,
    STC_EDGE_ARMED
  } stc_edge_state_t;
  typedef logic [7:0] stc_byte_t;
endpackage : stc_pkg

// ---- rtl/stc_bus_if.sv ----
`timescale 1ns/100ps
// register strobes passed from the bus slave into the counter core
interface stc_bus_if;
  logic       low_rd;
  logic       low_wr;
  logic       high_wr;
  logic [7:0] wdata;
  modport slave (output low_rd, output low_wr, output high_wr, output wdata);
  modport core  (input low_rd, input low_wr, input high_wr, input wdata);
endinterface : stc_bus_if

// ---- rtl/stc_prescale.sv ----
`timescale 1ns/100ps
`include "stc_consts.svh"
// prescaler: turns source ticks into counter increments
module stc_prescale (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_tick,
  input  wire logic       i_clear,
  input  wire logic [1:0] i_sel,
  output logic            o_inc
);
  import stc_pkg::*;
  logic [2:0] count;
  logic [2:0] limit;

  // limit is ratio minus one: 0,1,3,7
  assign limit = 3'((4'h1 << i_sel) - 4'h1);
  assign o_inc = i_tick && (count == limit);

  // --------------------------------------------------------------
  // prescale counter
  // --------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst || i_clear) begin
      count <= 3'h0;
    end else if (i_tick) begin
      count <= (count == limit) ? 3'h0 : count + 3'h1;
    end
  end
endmodule : stc_prescale

// ---- testbench/stc_timer_asserts.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// port checks for the timer
// ----------------------------------------
module stc_timer_asserts (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [7:0]  i_wb_adr,
  input wire logic        o_wb_ack,
  input wire logic        o_wb_err,
  input wire logic        i_low_power_osc_enable,
  input wire logic [3:0]  i_compare_mode_code,
  input wire logic        i_compare_match,
  input wire logic        i_adc_enable,
  input wire logic [1:0]  o_port_pins_oe_n,
  input wire logic [1:0]  o_port_pins_in,
  input wire logic        o_adc_start,
  input wire logic        o_timebase_this,
  input wire logic [15:0] o_count
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic       req;
  logic [2:0] quiet;
  assign req = i_wb_cyc && i_wb_stb && !o_wb_ack && !o_wb_err;
  // cycles since a bus write; a write may load any count value
  always_ff @(posedge i_clk) begin
    if (i_rst || (req && i_wb_we)) quiet <= 3'h0;
    else if (quiet != 3'h7) quiet <= quiet + 3'h1;
  end
  sequence s_trig;
    i_compare_mode_code == 4'hB && i_compare_match;
  endsequence
  sequence s_quiet;
    quiet == 3'h7;
  endsequence
  property p_ack;
    req && i_wb_adr <= 8'h14 && i_wb_adr[1:0] == 2'h0
      |=> o_wb_ack && !o_wb_err;
  endproperty
  property p_err;
    req && i_wb_adr > 8'h14 |=> o_wb_err && !o_wb_ack;
  endproperty
  property p_ack_drop;
    o_wb_ack |=> !o_wb_ack;
  endproperty
  property p_err_drop;
    o_wb_err |=> !o_wb_err;
  endproperty
  property p_pins;
    i_low_power_osc_enable
      |-> o_port_pins_oe_n == 2'h3 && o_port_pins_in == 2'h0;
  endproperty
  // the time base select shows on its output one cycle late
  property p_adc;
    s_trig ##0 i_adc_enable ##1 o_timebase_this |-> o_adc_start;
  endproperty
  property p_adc_cause;
    o_adc_start |-> $past(i_compare_mode_code) == 4'hB
      && $past(i_compare_match && i_adc_enable);
  endproperty
  property p_trig;
    s_trig ##0 s_quiet ##1 o_timebase_this |-> ##[0:1] o_count == 16'h0000;
  endproperty
  property p_step;
    s_quiet ##0 o_count != $past(o_count)
      |-> o_count == $past(o_count) + 16'h0001 || o_count == 16'h0000;
  endproperty
  a_ack: assert property (p_ack)
    else $error("no ack for mapped access");
  a_err: assert property (p_err)
    else $error("no err for unmapped access");
  a_ack_drop: assert property (p_ack_drop)
    else $error("ack held");
  a_err_drop: assert property (p_err_drop)
    else $error("err held");
  a_pins: assert property (p_pins)
    else $error("shared pins not inputs");
  a_adc: assert property (p_adc)
    else $error("no conversion start");
  a_adc_cause: assert property (p_adc_cause)
    else $error("stray conversion start");
  a_trig: assert property (p_trig)
    else $error("trigger left count");
  a_step: assert property (p_step)
    else $error("count jumped");
endmodule : stc_timer_asserts

// ---- testbench/stc_far_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// far side: edge source and compare unit
// ----------------------------------------
module stc_far_model (
  input  wire logic        i_clk,
  input  wire logic        i_ext_run,
  input  wire logic [15:0] i_count,
  input  wire logic [15:0] i_period,
  output logic             o_ext_count,
  output logic             o_match
);
  logic [1:0] div = 2'h0;
  logic       hit = 1'b0;
  initial o_ext_count = 1'b0;
  initial o_match = 1'b0;
  // edges idle low between bursts; slow enough for the sync path
  always @(posedge i_clk) begin
    div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
    if (!i_ext_run) o_ext_count <= 1'b0;
    else if (div == 2'h2) o_ext_count <= !o_ext_count;
  end
  // one pulse on arrival only, else the late count would retrigger
  always @(posedge i_clk) begin
    hit <= i_count == i_period;
    o_match <= i_count == i_period && !hit;
  end
endmodule : stc_far_model

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  logic i_clk = 0, i_rst = 1, cyc = 0, stb = 0, we = 0, run = 0, osc = 0;
  logic aen = 0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000, rng = 32'h0000_8156;
  logic [3:0]  mode = 4'h0;
  logic [15:0] per = 16'hFFFF;
  wire logic [31:0] rdat;
  wire logic ack, err, ext, match, tbs, adc, irq;
  wire logic [1:0]  oe_n, pin_in;
  wire logic [15:0] cnt;
  int error_cnt = 0, tests_run = 0, rises = 0, adcs = 0;
  logic ext_d = 0;
  always #2.5 i_clk = ~i_clk;
  stc_timer dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(dat),
    .i_wb_sel(4'hF), .o_wb_dat(rdat), .o_wb_ack(ack), .o_wb_err(err),
    .i_ext_count(ext), .i_osc_clk(ext), .i_low_power_osc_enable(osc),
    .i_compare_mode_code(mode), .i_compare_match(match),
    .i_adc_enable(aen), .i_port_pins(2'h3), .i_port_direction_reg(2'h1),
    .o_port_pins_oe_n(oe_n), .o_port_pins_in(pin_in),
    .o_timebase_this(tbs), .o_adc_start(adc), .o_count(cnt), .o_irq(irq));
  stc_far_model far_u (.i_clk(i_clk), .i_ext_run(run), .i_count(cnt),
    .i_period(per), .o_ext_count(ext), .o_match(match));
  // bench model: edges offered and conversions started
  always @(posedge i_clk) begin
    ext_d <= ext;
    if (ext && !ext_d) rises++;
    if (adc) adcs++;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  // one classic cycle; held until ack or err is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] r, output logic e);
    int n;
    n = 0;
    @(posedge i_clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h0, d};
    do begin
      @(posedge i_clk);
      n++;
    end while (!(ack || err) && n < 50);
    r = rdat[7:0];
    e = err;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    wb(1'b1, a, d, r, e);
  endtask : wr
  task automatic settle();
    repeat (2) @(posedge i_clk);
    #1;
  endtask : settle
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // start and stop land off the count grid, so allow one step
  task automatic near(input logic [15:0] g, input int e);
    chk({15'h0, g >= 16'(e - 1) && g <= 16'(e + 1)}, 16'h0001);
  endtask : near
  task automatic give_verdict();
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    #150000;
    error_cnt++;
    give_verdict();
  end
  initial begin : main
    logic [7:0] r, hi, lo;
    logic e;
    logic [15:0] c;
    int a0;
    repeat (8) @(posedge i_clk);
    i_rst <= 0;
    wb(1'b0, 8'h08, 8'h00, r, e);
    chk({8'h0, r}, 16'h0000);
    wb(1'b0, 8'h18, 8'h00, r, e);
    chk({15'h0, e}, 16'h0001);
    rng = xs(rng);
    {hi, lo} = rng[15:0];
    wr(8'h08, 8'h80);
    wr(8'h04, hi);
    settle();
    chk(cnt, 16'h0000);
    wr(8'h00, lo);
    settle();
    chk(cnt, {hi, lo});
    wb(1'b0, 8'h04, 8'h00, r, e);
    chk({8'h0, r}, {8'h0, hi});
    wr(8'h04, ~hi);
    wb(1'b0, 8'h00, 8'h00, r, e);
    chk({8'h0, r}, {8'h0, lo});
    wb(1'b0, 8'h04, 8'h00, r, e);
    chk({8'h0, r}, {8'h0, hi});
    wr(8'h08, 8'h00);
    wr(8'h04, ~hi);
    settle();
    chk(cnt, {~hi, lo});
    for (int k = 0; k < 7; k++) begin
      wr(8'h04, 8'h00);
      wr(8'h00, 8'h00);
      osc <= k == 6;
      wr(8'h08, k < 4 ? {2'b00, 2'(k), 4'h1} : (k == 5 ? 8'h07 : 8'h03));
      rises = 0;
      run <= k > 3;
      repeat (128) @(posedge i_clk);
      run <= 0;
      if (k > 3) repeat (8) @(posedge i_clk);
      if (k == 6) chk({12'h0, oe_n, pin_in}, 16'h000C);
      if (k == 5) chk({12'h0, oe_n, pin_in}, 16'h0007);
      wr(8'h08, 8'h00);
      settle();
      c = cnt;
      if (k < 4) near(c, 128 / (4 << k));
      else near(c, rises - 1);
      repeat (20) @(posedge i_clk);
      chk(cnt, c);
    end
    osc <= 0;
    wr(8'h04, 8'hFF);
    wr(8'h00, 8'hFF);
    wr(8'h08, 8'h01);
    repeat (12) @(posedge i_clk);
    wr(8'h08, 8'h00);
    wb(1'b0, 8'h0C, 8'h00, r, e);
    chk({7'h0, r, irq}, 16'h0002);
    wr(8'h10, 8'h01);
    settle();
    chk({15'h0, irq}, 16'h0001);
    wr(8'h0C, 8'h01);
    settle();
    chk({15'h0, irq}, 16'h0000);
    wr(8'h00, 8'h00);
    {per, mode, aen} <= {16'h0010, 4'hB, 1'b1};
    wr(8'h08, 8'h41);
    repeat (300) @(posedge i_clk);
    wr(8'h08, 8'h00);
    mode <= 4'h0;
    wb(1'b0, 8'h0C, 8'h00, r, e);
    chk({8'h0, r}, 16'h0000);
    chk({14'h0, cnt <= 16'h0011, adcs > 2}, 16'h0003);
    // other timer selected: a trigger must leave this count alone
    a0 = adcs;
    mode <= 4'hB;
    wr(8'h00, 8'h00);
    wr(8'h08, 8'h01);
    repeat (120) @(posedge i_clk);
    wr(8'h08, 8'h00);
    mode <= 4'h0;
    settle();
    chk({15'h0, cnt > 16'h0011 && adcs == a0}, 16'h0001);
    wr(8'h08, 8'h40);
    settle();
    chk({15'h0, tbs}, 16'h0001);
    wr(8'h08, 8'h08);
    settle();
    chk({15'h0, tbs}, 16'h0000);
    give_verdict();
  end
endmodule : tb_top
bind stc_timer stc_timer_asserts chk_u (.i_clk(i_clk), .i_rst(i_rst),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
  .i_wb_adr(i_wb_adr), .o_wb_ack(o_wb_ack), .o_wb_err(o_wb_err),
  .i_low_power_osc_enable(i_low_power_osc_enable),
  .i_compare_mode_code(i_compare_mode_code),
  .i_compare_match(i_compare_match), .i_adc_enable(i_adc_enable),
  .o_port_pins_oe_n(o_port_pins_oe_n), .o_port_pins_in(o_port_pins_in),
  .o_adc_start(o_adc_start), .o_timebase_this(o_timebase_this),
  .o_count(o_count));
